// ---- rtl/pwev_regs.sv ----
// Wake status, regulator fault reset and interrupt configuration registers.
// Assumes the command decoder delivers one-cycle strobes on clk, and the
// fault, warning and state inputs come from logic on the same clock.
// nrst is the power-on reset of the device.
//
// Operation
// - Deglitched wake rising edge sets the wake latch, held until cleared.
// - Clear-rouse-latch command with data 0x8E clears the wake latch.
// - Entering the OFF state clears the wake latch.
// - Status bit 0 shows the deglitched wake level, zero after power-on.
// - Configuration writes land only in DIAGNOSTIC with the lock bit 0.
// - Configuration contents are exported to the configuration checksum.
// - Overvoltage reset enables at bits 7,5,4, default 0, raise global reset.
// - Undervoltage reset enables at bits 3,1,0, default 1, raise global reset.
// - Enabled interrupt condition drives pin low, clears driver bit, goes SAFE.
// - Thermal warning sets its status bit whatever the enable.
// - Thermal warning enables at bits 3,1,0, default 0, raise interrupt.
// - Input-low enable at bit 4 makes input-low detection an interrupt.
`timescale 1ns/1ps
module pwev_regs
  import pwev_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wake_pin,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [2:0]  reg_idx,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        clear_rouse_latch_cmd,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        in_diagnostic,
  input  wire logic        cfg_lock,
  input  wire logic        enter_off,
  input  wire logic [2:0]  overvolt_evt,
  input  wire logic [2:0]  undervolt_evt,
  input  wire logic [2:0]  thermal_warn_evt,
  input  wire logic        input_low_evt,
  output logic             global_reset_req,
  output logic             global_irq,
  output logic             driver_enable_irq_pin,
  output logic             driver_output_enable_clr,
  output logic             safe_state_req,
  output logic      [23:0] config_checksum_data
);

  typedef struct packed {
    logic [7:0] fault_cfg;
    logic [7:0] therm_cfg;
    logic [7:0] vin_cfg;
    logic       wake_latch;
    logic [2:0] therm_stat;
    logic [7:0] rdata;
    logic       rst_req;
    logic       irq;
  } pwev_state_s;

  pwev_state_s st_q;
  pwev_state_s st_d;
  logic        wake_level;
  logic        wake_rise;
  logic        cfg_open;
  logic [2:0]  ov_en;
  logic [2:0]  uv_en;
  logic [2:0]  ot_en;

  pwev_deglitch u_wake (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (wake_pin),
    .level (wake_level),
    .rise  (wake_rise)
  );

  // ******************************************************************
  // Field pick-out
  // ******************************************************************
  assign cfg_open = in_diagnostic & ~cfg_lock;
  assign ov_en    = {st_q.fault_cfg[PWEV_BOOST_OV_BIT], st_q.fault_cfg[PWEV_LV_OV_BIT],
                     st_q.fault_cfg[PWEV_WIDE_OV_BIT]};
  assign uv_en    = {st_q.fault_cfg[PWEV_BOOST_UV_BIT], st_q.fault_cfg[PWEV_LV_UV_BIT],
                     st_q.fault_cfg[PWEV_WIDE_UV_BIT]};
  assign ot_en    = {st_q.therm_cfg[PWEV_BOOST_OT_BIT], st_q.therm_cfg[PWEV_LV_OT_BIT],
                     st_q.therm_cfg[PWEV_WIDE_OT_BIT]};

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    st_d = st_q;
    // Set wins over a clear in the same cycle
    if (clear_rouse_latch_cmd && cmd_data == PWEV_CLEAR_ROUSE_DATA) begin
      st_d.wake_latch = 1'b0;
    end
    if (enter_off) begin
      st_d.wake_latch = 1'b0;
    end
    if (wake_rise) begin
      st_d.wake_latch = 1'b1;
    end
    st_d.therm_stat = st_q.therm_stat | thermal_warn_evt;
    if (reg_wr && cfg_open) begin
      unique case (reg_idx)
        PWEV_IDX_FAULT_RESET_CFG: st_d.fault_cfg = reg_wdata & PWEV_FAULT_WMASK;
        PWEV_IDX_THERMAL_IRQ_CFG: st_d.therm_cfg = reg_wdata & PWEV_THERMAL_WMASK;
        PWEV_IDX_INPUT_V_IRQ_CFG: st_d.vin_cfg   = reg_wdata & PWEV_INPUT_V_WMASK;
        default:                  st_d.fault_cfg = st_q.fault_cfg;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_idx)
        PWEV_IDX_EVENT_STATUS_TWO: begin
          st_d.rdata                      = '0;
          st_d.rdata[PWEV_WAKE_LEVEL_BIT] = wake_level;
          st_d.rdata[PWEV_WAKE_LATCH_BIT] = st_q.wake_latch;
        end
        PWEV_IDX_FAULT_RESET_CFG:   st_d.rdata = st_q.fault_cfg;
        PWEV_IDX_THERMAL_IRQ_CFG:   st_d.rdata = st_q.therm_cfg;
        PWEV_IDX_INPUT_V_IRQ_CFG:   st_d.rdata = st_q.vin_cfg;
        PWEV_IDX_THERMAL_WARN_STAT: st_d.rdata = {5'h0, st_q.therm_stat};
        default:                    st_d.rdata = '0;
      endcase
    end
    st_d.rst_req = |(overvolt_evt & ov_en) | |(undervolt_evt & uv_en);
    st_d.irq     = |(thermal_warn_evt & ot_en)
                 | (input_low_evt & st_q.vin_cfg[PWEV_INPUT_LOW_BIT]);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q            <= '0;
      st_q.fault_cfg  <= PWEV_FAULT_RESET_INIT;
      st_q.therm_cfg  <= PWEV_THERMAL_INIT;
      st_q.vin_cfg    <= PWEV_INPUT_V_INIT;
    end else begin
      st_q <= st_d;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign reg_rdata                = st_q.rdata;
  assign global_reset_req         = st_q.rst_req;
  assign global_irq               = st_q.irq;
  assign driver_enable_irq_pin    = ~st_q.irq;
  assign driver_output_enable_clr = st_q.irq;
  assign safe_state_req           = st_q.irq;
  assign config_checksum_data     = {st_q.fault_cfg, st_q.therm_cfg, st_q.vin_cfg};

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_wake_set;
    wake_rise |=> st_q.wake_latch;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake latch not set");

  property p_wake_clr;
    clear_rouse_latch_cmd && cmd_data == PWEV_CLEAR_ROUSE_DATA && !wake_rise |=> !st_q.wake_latch;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake latch not cleared");

  property p_wake_keep;
    st_q.wake_latch && !enter_off && !(clear_rouse_latch_cmd && cmd_data == PWEV_CLEAR_ROUSE_DATA)
      |=> st_q.wake_latch;
  endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("wake latch dropped");

  property p_off_clr;
    enter_off && !wake_rise |=> !st_q.wake_latch;
  endproperty
  a_off_clr: assert property (p_off_clr) else $error("wake latch kept at off");

  property p_stat_read;
    reg_rd && reg_idx == PWEV_IDX_EVENT_STATUS_TWO
      |=> reg_rdata == {6'h0, $past(st_q.wake_latch), $past(wake_level)};
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");

  property p_wr_block;
    reg_wr && !cfg_open |=> $stable(config_checksum_data);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("locked write landed");

  // Open write, one idle cycle, then a read back of the same register
  property p_wr_take;
    reg_wr && cfg_open && reg_idx == PWEV_IDX_FAULT_RESET_CFG ##1 !reg_wr
      ##1 reg_rd && reg_idx == PWEV_IDX_FAULT_RESET_CFG |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("open write lost");

  property p_ov_reset;
    overvolt_evt[2] && st_q.fault_cfg[PWEV_BOOST_OV_BIT] |=> global_reset_req;
  endproperty
  a_ov_reset: assert property (p_ov_reset) else $error("boost overvolt no reset");

  property p_uv_quiet;
    overvolt_evt == 3'h0 && (undervolt_evt & uv_en) == 3'h0 |=> !global_reset_req;
  endproperty
  a_uv_quiet: assert property (p_uv_quiet) else $error("reset without cause");

  property p_ot_stat;
    thermal_warn_evt[0] |=> st_q.therm_stat[0] ##1 st_q.therm_stat[0];
  endproperty
  a_ot_stat: assert property (p_ot_stat) else $error("thermal status not set");

  property p_ot_irq;
    thermal_warn_evt[2] && st_q.therm_cfg[PWEV_BOOST_OT_BIT]
      |=> !driver_enable_irq_pin && driver_output_enable_clr && safe_state_req;
  endproperty
  a_ot_irq: assert property (p_ot_irq) else $error("thermal irq missing");

  property p_vin_irq;
    input_low_evt && st_q.vin_cfg[PWEV_INPUT_LOW_BIT] |=> global_irq && !driver_enable_irq_pin;
  endproperty
  a_vin_irq: assert property (p_vin_irq) else $error("input low irq missing");

  c_wake_rise:  cover property (wake_rise ##1 st_q.wake_latch);
  c_open_write: cover property (reg_wr && cfg_open && reg_idx == PWEV_IDX_THERMAL_IRQ_CFG);
  c_irq:        cover property (!driver_enable_irq_pin);
  c_reset_req:  cover property (global_reset_req);

endmodule

// ---- rtl/pwev_pkg.sv ----
// Package for the wake status and event configuration register bank.
// Assumes a 200 MHz clk; register indices are local to this block.
package pwev_pkg;

  // ******************************************************************
  // Register indices and access
  // ******************************************************************
  localparam logic [2:0] PWEV_IDX_EVENT_STATUS_TWO  = 3'h0;
  localparam logic [2:0] PWEV_IDX_FAULT_RESET_CFG   = 3'h1;
  localparam logic [2:0] PWEV_IDX_THERMAL_IRQ_CFG   = 3'h2;
  localparam logic [2:0] PWEV_IDX_INPUT_V_IRQ_CFG   = 3'h3;
  localparam logic [2:0] PWEV_IDX_THERMAL_WARN_STAT = 3'h4;

  localparam logic [7:0] PWEV_CLEAR_ROUSE_DATA = 8'h8E;

  // ******************************************************************
  // Reset values and writable bits
  // ******************************************************************
  localparam logic [7:0] PWEV_FAULT_RESET_INIT = 8'h0B;
  localparam logic [7:0] PWEV_THERMAL_INIT     = 8'h00;
  localparam logic [7:0] PWEV_INPUT_V_INIT     = 8'h00;
  localparam logic [7:0] PWEV_FAULT_WMASK      = 8'hFF;
  localparam logic [7:0] PWEV_THERMAL_WMASK    = 8'h0B;
  localparam logic [7:0] PWEV_INPUT_V_WMASK    = 8'h10;

  // ******************************************************************
  // Field positions; regulator vectors are [2]=boost [1]=lv [0]=wide
  // ******************************************************************
  localparam int PWEV_BOOST_OV_BIT   = 7;
  localparam int PWEV_LV_OV_BIT      = 5;
  localparam int PWEV_WIDE_OV_BIT    = 4;
  localparam int PWEV_BOOST_UV_BIT   = 3;
  localparam int PWEV_LV_UV_BIT      = 1;
  localparam int PWEV_WIDE_UV_BIT    = 0;
  localparam int PWEV_BOOST_OT_BIT   = 3;
  localparam int PWEV_LV_OT_BIT      = 1;
  localparam int PWEV_WIDE_OT_BIT    = 0;
  localparam int PWEV_INPUT_LOW_BIT  = 4;
  localparam int PWEV_WAKE_LEVEL_BIT = 0;
  localparam int PWEV_WAKE_LATCH_BIT = 1;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int PWEV_CLK_PERIOD_PS    = 5000;
  localparam int PWEV_WAKE_DEGLITCH_NS = 10000;
  localparam int PWEV_WAKE_DEGLITCH_CYC =
    (PWEV_WAKE_DEGLITCH_NS * 1000 + PWEV_CLK_PERIOD_PS - 1) / PWEV_CLK_PERIOD_PS;
  localparam int PWEV_DGL_W = $clog2(PWEV_WAKE_DEGLITCH_CYC + 1);

endpackage

// ---- rtl/pwev_deglitch.sv ----
// Wake pin synchroniser and deglitch filter with rising edge pulse.
// Assumes an asynchronous pin and a free running clk.
`timescale 1ns/1ps
module pwev_deglitch
  import pwev_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic                  sync1;
    logic                  sync2;
    logic [PWEV_DGL_W-1:0] cnt;
    logic                  level;
    logic                  rise;
  } pwev_dgl_s;

  localparam logic [PWEV_DGL_W-1:0] DGL_LAST = PWEV_DGL_W'(PWEV_WAKE_DEGLITCH_CYC - 1);

  pwev_dgl_s st_q;
  pwev_dgl_s st_d;

  // ******************************************************************
  // Filter: level changes only after a steady run of samples
  // ******************************************************************
  always_comb begin
    st_d       = st_q;
    st_d.sync1 = pin;
    st_d.sync2 = st_q.sync1;
    st_d.rise  = 1'b0;
    if (st_q.sync2 == st_q.level) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == DGL_LAST) begin
      st_d.cnt   = '0;
      st_d.level = st_q.sync2;
      st_d.rise  = st_q.sync2;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.level;
  assign rise  = st_q.rise;

endmodule

// ---- bench/pwev_mcu_model.sv ----
// Controller model: register reads, writes and the clear-wake command.
// Assumes the bank samples on the rising edge; requests launch on the falling edge.
`timescale 1ns/1ps
module pwev_mcu_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [2:0] reg_idx,
  output logic      [7:0] reg_wdata,
  output logic            clear_rouse_latch_cmd,
  output logic      [7:0] cmd_data
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_idx = 3'h0;
    reg_wdata = 8'h00;
    clear_rouse_latch_cmd = 1'b0;
    cmd_data = 8'h00;
  end

  // Released data lines show the inverse so stale values never pass
  task automatic wr(input logic [2:0] idx, input logic [7:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_idx = idx;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~data;
  endtask

  task automatic rd(input logic [2:0] idx, output logic [7:0] data);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_idx = idx;
    @(negedge clk);
    reg_rd = 1'b0;
    data = reg_rdata;
  endtask

  task automatic clr(input logic [7:0] data);
    @(negedge clk);
    clear_rouse_latch_cmd = 1'b1;
    cmd_data = data;
    @(negedge clk);
    clear_rouse_latch_cmd = 1'b0;
    cmd_data = ~data;
  endtask
endmodule

// ---- bench/pwev_regs_tb_top.sv ----
// Testbench for the wake status and event configuration bank.
// Assumes the controller model drives the register port; events come from here.
`timescale 1ns/1ps
module pwev_regs_tb_top;
  import pwev_pkg::*;
  logic        clk;
  logic        nrst;
  logic        wake_pin;
  logic        reg_wr;
  logic        reg_rd;
  logic [2:0]  reg_idx;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        clear_rouse_latch_cmd;
  logic [7:0]  cmd_data;
  logic        in_diagnostic;
  logic        cfg_lock;
  logic        enter_off;
  logic [2:0]  ov;
  logic [2:0]  uv;
  logic [2:0]  tw;
  logic        il;
  logic        global_reset_req;
  logic        global_irq;
  logic        driver_enable_irq_pin;
  logic        driver_output_enable_clr;
  logic        safe_state_req;
  logic [23:0] config_checksum_data;
  int          fails;
  int          checked;
  int          ovb [3] = '{4, 5, 7};
  int          uvb [3] = '{0, 1, 3};

  pwev_regs dut (.clk(clk), .nrst(nrst), .wake_pin(wake_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .clear_rouse_latch_cmd(clear_rouse_latch_cmd), .cmd_data(cmd_data), .in_diagnostic(in_diagnostic),
    .cfg_lock(cfg_lock), .enter_off(enter_off), .overvolt_evt(ov), .undervolt_evt(uv),
    .thermal_warn_evt(tw), .input_low_evt(il), .global_reset_req(global_reset_req),
    .global_irq(global_irq), .driver_enable_irq_pin(driver_enable_irq_pin),
    .driver_output_enable_clr(driver_output_enable_clr), .safe_state_req(safe_state_req),
    .config_checksum_data(config_checksum_data));

  pwev_mcu_model mcu (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .clear_rouse_latch_cmd(clear_rouse_latch_cmd),
    .cmd_data(cmd_data));

  // ******************************************************************
  // Checking tasks
  // ******************************************************************
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rchk(input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    mcu.rd(idx, d);
    chk($sformatf("reg%0d", idx), {16'h0000, d}, {16'h0000, exp});
  endtask

  // Applies event levels for one cycle and checks the outputs one cycle later
  task automatic ev(input logic [2:0] o, u, t, input logic l, er, ei);
    @(negedge clk);
    ov = o;
    uv = u;
    tw = t;
    il = l;
    @(negedge clk);
    chk("events", {19'h0, global_reset_req, global_irq, driver_enable_irq_pin, driver_output_enable_clr,
      safe_state_req}, {19'h0, er, ei, ~ei, ei, ei});
    ov = 3'h0;
    uv = 3'h0;
    tw = 3'h0;
    il = 1'b0;
  endtask

  task automatic wrap_up;
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ******************************************************************
  // Clock, watchdog and main sequence
  // ******************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #400000;
    fails++;
    wrap_up;
  end

  initial begin
    {nrst, wake_pin, in_diagnostic, cfg_lock, enter_off, ov, uv, tw, il} = '0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    rchk(3'h0, 8'h00);
    rchk(3'h1, 8'h0B);
    rchk(3'h2, 8'h00);
    rchk(3'h3, 8'h00);
    rchk(3'h7, 8'h00);
    chk("checksum", config_checksum_data, 24'h0B_0000);
    ev(3'h7, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    ev(3'h0, 3'h7, 3'h0, 1'b0, 1'b1, 1'b0);
    ev(3'h0, 3'h0, 3'h4, 1'b0, 1'b0, 1'b0);
    rchk(3'h4, 8'h04);
    ev(3'h0, 3'h0, 3'h0, 1'b1, 1'b0, 1'b0);
    mcu.wr(3'h1, 8'hF0);
    rchk(3'h1, 8'h0B);
    in_diagnostic = 1'b1;
    cfg_lock = 1'b1;
    mcu.wr(3'h1, 8'hF0);
    rchk(3'h1, 8'h0B);
    cfg_lock = 1'b0;
    mcu.wr(3'h1, 8'hF0);
    rchk(3'h1, 8'hF0);
    mcu.wr(3'h2, 8'hFF);
    rchk(3'h2, 8'h0B);
    mcu.wr(3'h3, 8'hFF);
    rchk(3'h3, 8'h10);
    mcu.wr(3'h0, 8'hFF);
    rchk(3'h0, 8'h00);
    chk("checksum", config_checksum_data, 24'hF0_0B10);
    ev(3'h0, 3'h0, 3'h0, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      mcu.wr(3'h1, 8'h01 << ovb[i]);
      for (int j = 0; j < 3; j++) ev(3'h1 << j, 3'h0, 3'h0, 1'b0, i == j, 1'b0);
      mcu.wr(3'h1, 8'h01 << uvb[i]);
      for (int j = 0; j < 3; j++) ev(3'h0, 3'h1 << j, 3'h0, 1'b0, i == j, 1'b0);
      mcu.wr(3'h2, 8'h01 << uvb[i]);
      for (int j = 0; j < 3; j++) ev(3'h0, 3'h0, 3'h1 << j, 1'b0, 1'b0, i == j);
    end
    rchk(3'h4, 8'h07);
    wake_pin = 1'b1;
    repeat (2100) @(negedge clk);
    rchk(3'h0, 8'h03);
    wake_pin = 1'b0;
    repeat (2100) @(negedge clk);
    rchk(3'h0, 8'h02);
    mcu.clr(8'h8F);
    rchk(3'h0, 8'h02);
    mcu.clr(8'h8E);
    rchk(3'h0, 8'h00);
    wake_pin = 1'b1;
    repeat (2100) @(negedge clk);
    enter_off = 1'b1;
    @(negedge clk);
    enter_off = 1'b0;
    rchk(3'h0, 8'h01);
    wake_pin = 1'b0;
    repeat (2100) @(negedge clk);
    wake_pin = 1'b1;
    repeat (1000) @(negedge clk);
    wake_pin = 1'b0;
    repeat (2100) @(negedge clk);
    rchk(3'h0, 8'h00);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rchk(3'h1, 8'h0B);
    rchk(3'h2, 8'h00);
    rchk(3'h4, 8'h00);
    wrap_up;
  end
endmodule
